/* rtl/mrc_pkg.sv */
package mrc_pkg;
    // Register offsets (byte addresses on the internal register space)
    localparam logic [11:0] MRC_OFF_RESET_REV  = 12'h000;
    localparam logic [11:0] MRC_OFF_MASTER_CFG = 12'h010;
    localparam int          MRC_ADDR_W         = 12;
    localparam int          MRC_DATA_W         = 16;

    // Reset / revision register fields
    localparam int          MRC_RST_BIT        = 0;
    localparam int          MRC_REV_LSB        = 8;
    localparam int          MRC_REV_W          = 8;

    // Master configuration fields
    localparam int          MRC_RX_EN_BIT      = 0;
    localparam int          MRC_RX_BURST_LSB   = 1;
    localparam int          MRC_TX_EN_BIT      = 3;
    localparam int          MRC_TX_BURST_LSB   = 4;
    localparam int          MRC_ORDER_BIT      = 6;
    localparam int          MRC_TESTER_LSB     = 7;
    localparam int          MRC_TESTER_W       = 5;
    localparam int          MRC_RX_ARB_LSB     = 12;
    localparam int          MRC_TX_ARB_LSB     = 14;

    // Reset values
    localparam logic [15:0] MRC_CFG_RESET      = 16'h0000;

    // Burst limits in dwords
    localparam logic [8:0]  MRC_BURST_32       = 9'h020;
    localparam logic [8:0]  MRC_BURST_64       = 9'h040;
    localparam logic [8:0]  MRC_BURST_128      = 9'h080;
    localparam logic [8:0]  MRC_BURST_256      = 9'h100;

    // Tester port codes
    localparam logic [4:0]  MRC_TESTER_HS0     = 5'h10;
    localparam logic [4:0]  MRC_TESTER_HS1     = 5'h11;

    // Size of strict-priority groups per arbitration code
    localparam logic [6:0]  MRC_PRIO_NONE      = 7'h00;
    localparam logic [6:0]  MRC_PRIO_2         = 7'h02;
    localparam logic [6:0]  MRC_PRIO_16        = 7'h10;
    localparam logic [6:0]  MRC_PRIO_64        = 7'h40;

    typedef enum logic [1:0] {
        MRC_ARB_RR   = 2'h0,
        MRC_ARB_P2   = 2'h1,
        MRC_ARB_P16  = 2'h2,
        MRC_ARB_P64  = 2'h3
    } mrc_arb_t;

    // Burst code to dword limit; used for both directions
    function automatic logic [8:0] mrc_burst_len(input logic [1:0] code);
        case (code)
            2'h0:    mrc_burst_len = MRC_BURST_32;
            2'h1:    mrc_burst_len = MRC_BURST_64;
            2'h2:    mrc_burst_len = MRC_BURST_128;
            default: mrc_burst_len = MRC_BURST_256;
        endcase
    endfunction : mrc_burst_len

    // Arbitration code to size of the strict-priority group
    function automatic logic [6:0] mrc_prio_size(input logic [1:0] code);
        case (code)
            MRC_ARB_P2:  mrc_prio_size = MRC_PRIO_2;
            MRC_ARB_P16: mrc_prio_size = MRC_PRIO_16;
            MRC_ARB_P64: mrc_prio_size = MRC_PRIO_64;
            default:     mrc_prio_size = MRC_PRIO_NONE;
        endcase
    endfunction : mrc_prio_size
endpackage : mrc_pkg

/* rtl/mrc_byte_order.sv */
// Swaps packet data lanes for big-endian transfers; other traffic passes straight
module mrc_byte_order (
    input  wire logic        big_endian_i,
    input  wire logic        is_packet_i,
    input  wire logic [31:0] data_i,
    output logic      [31:0] data_o
);
    import mrc_pkg::*;

    // Only packet data honours the order bit; registers stay little-endian
    always_comb begin
        if (big_endian_i && is_packet_i) begin
            data_o = {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]};
        end else begin
            data_o = data_i;
        end
    end
endmodule : mrc_byte_order

/* rtl/mrc_decode.sv */
// Decodes the tester port field into a one-hot port select
module mrc_decode #(
    parameter int NUM_PORTS = 16
) (
    input  wire logic [4:0]           code_i,
    output logic      [NUM_PORTS-1:0] port_sel_o,
    output logic      [1:0]           hs_sel_o,
    output logic                      valid_o
);
    import mrc_pkg::*;

    // Low ports by index, two high-speed ports, the rest unused
    always_comb begin
        port_sel_o = '0;
        hs_sel_o   = 2'h0;
        valid_o    = 1'b1;
        if (!code_i[4]) begin
            port_sel_o[code_i[3:0]] = 1'b1;
        end else if (code_i == MRC_TESTER_HS0) begin
            hs_sel_o[0] = 1'b1;
        end else if (code_i == MRC_TESTER_HS1) begin
            hs_sel_o[1] = 1'b1;
        end else begin
            valid_o = 1'b0; // Unused codes attach the tester nowhere
        end
    end
endmodule : mrc_decode

/* rtl/mrc_master_regs.sv */
module mrc_master_regs #(
    parameter logic [7:0] REVISION  = 8'h01, // Arbitrary value
    parameter int         NUM_CHAN  = 64,
    parameter int         NUM_PORTS = 16
) (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    // Register access
    input  wire logic                           reg_sel_i,
    input  wire logic                           reg_wr_i,
    input  wire logic [mrc_pkg::MRC_ADDR_W-1:0] reg_addr_i,
    input  wire logic [mrc_pkg::MRC_DATA_W-1:0] reg_wdata_i,
    output logic      [mrc_pkg::MRC_DATA_W-1:0] reg_rdata_o,
    // PCI driver enable, low while driving
    output logic                                pci_oe_n_o,
    // Software reset out to the rest of the device
    output logic                                soft_reset_o,
    // Receive DMA gate and burst limit
    input  wire logic                           rx_dma_req_i,
    output logic                                rx_dma_go_o,
    output logic      [8:0]                     rx_burst_max_o,
    // Transmit DMA gate and burst limit
    input  wire logic                           tx_dma_req_i,
    output logic                                tx_dma_go_o,
    output logic      [8:0]                     tx_burst_max_o,
    // Packet data byte ordering
    input  wire logic                           data_is_packet_i,
    input  wire logic [31:0]                    data_i,
    output logic      [31:0]                    data_o,
    // Tester port select
    output logic      [NUM_PORTS-1:0]           tester_port_o,
    output logic      [1:0]                     tester_hs_o,
    // Channel arbiters
    input  wire logic [NUM_CHAN-1:0]            rx_chan_req_i,
    output logic      [NUM_CHAN-1:0]            rx_chan_gnt_o,
    input  wire logic [NUM_CHAN-1:0]            tx_chan_req_i,
    output logic      [NUM_CHAN-1:0]            tx_chan_gnt_o
);
    import mrc_pkg::*;

    localparam int CW = $clog2(NUM_CHAN);

    logic        soft_reset;
    logic        next_soft_reset;
    logic [15:0] master_configuration;
    logic [15:0] next_master_configuration;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic [31:0] swapped;
    logic [NUM_PORTS-1:0] port_sel;
    logic [1:0]           hs_sel;
    logic [CW-1:0] rx_ptr;
    logic [CW-1:0] next_rx_ptr;
    logic [CW-1:0] tx_ptr;
    logic [CW-1:0] next_tx_ptr;
    logic [NUM_CHAN-1:0] rx_gnt;
    logic [NUM_CHAN-1:0] tx_gnt;

    // Grant: lowest requester inside the priority group, else round robin
    function automatic logic [NUM_CHAN-1:0] arb_pick(
        input logic [NUM_CHAN-1:0] req,
        input logic [1:0]          code,
        input logic [CW-1:0]       ptr
    );
        logic [NUM_CHAN-1:0] gnt;
        logic [6:0]          group;
        logic                done;
        int                  idx;
        gnt   = '0;
        group = mrc_prio_size(code);
        done  = 1'b0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (!done && req[i] && (i < int'(group))) begin
                gnt[i] = 1'b1;
                done   = 1'b1;
            end
        end
        for (int k = 0; k < NUM_CHAN; k++) begin
            idx = (int'(ptr) + k) % NUM_CHAN;
            if (!done && req[idx] && (idx >= int'(group))) begin
                gnt[idx] = 1'b1;
                done     = 1'b1;
            end
        end
        arb_pick = gnt;
    endfunction : arb_pick

    // Pointer to start the next round-robin search just past the winner
    function automatic logic [CW-1:0] arb_next(
        input logic [NUM_CHAN-1:0] gnt,
        input logic [CW-1:0]       ptr
    );
        logic [CW-1:0] nxt;
        nxt = ptr;
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (gnt[i]) begin
                nxt = CW'((i + 1) % NUM_CHAN);
            end
        end
        arb_next = nxt;
    endfunction : arb_next

    // Register writes; software reset zeroes configuration while it stands
    always_comb begin
        next_soft_reset           = soft_reset;
        next_master_configuration = master_configuration;
        if (reg_sel_i && reg_wr_i && reg_addr_i == MRC_OFF_RESET_REV) begin
            next_soft_reset = reg_wdata_i[MRC_RST_BIT];
        end
        if (reg_sel_i && reg_wr_i && reg_addr_i == MRC_OFF_MASTER_CFG) begin
            next_master_configuration = reg_wdata_i;
        end
        if (soft_reset) begin
            next_master_configuration = MRC_CFG_RESET;
        end
    end

    // Read data is registered; unmapped offsets read zero
    always_comb begin
        next_rdata = 16'h0000;
        if (reg_sel_i && !reg_wr_i) begin
            case (reg_addr_i)
                MRC_OFF_RESET_REV:  next_rdata = {REVISION, 7'h00, soft_reset};
                MRC_OFF_MASTER_CFG: next_rdata = master_configuration;
                default:            next_rdata = 16'h0000;
            endcase
        end
    end

    // Only the pin reset clears everything, including the reset bit
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            soft_reset           <= 1'b0;
            master_configuration <= MRC_CFG_RESET;
            rdata                <= 16'h0000;
        end else begin
            soft_reset           <= next_soft_reset;
            master_configuration <= next_master_configuration;
            rdata                <= next_rdata;
        end
    end

    // Arbiter pointers; held at zero during software reset
    always_comb begin
        next_rx_ptr = soft_reset ? '0 : arb_next(rx_gnt, rx_ptr);
        next_tx_ptr = soft_reset ? '0 : arb_next(tx_gnt, tx_ptr);
    end

    always_comb begin
        rx_gnt = arb_pick(rx_chan_req_i, master_configuration[MRC_RX_ARB_LSB +: 2], rx_ptr);
        tx_gnt = arb_pick(tx_chan_req_i, master_configuration[MRC_TX_ARB_LSB +: 2], tx_ptr);
    end

    mrc_byte_order u_order (
        .big_endian_i (master_configuration[MRC_ORDER_BIT]),
        .is_packet_i  (data_is_packet_i),
        .data_i       (data_i),
        .data_o       (swapped)
    );

    mrc_decode #(
        .NUM_PORTS (NUM_PORTS)
    ) u_decode (
        .code_i     (master_configuration[MRC_TESTER_LSB +: MRC_TESTER_W]),
        .port_sel_o (port_sel),
        .hs_sel_o   (hs_sel),
        .valid_o    ()
    );

    // Registered outputs; PCI drivers float only under the pin reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_ptr         <= '0;
            tx_ptr         <= '0;
            pci_oe_n_o     <= 1'b1;
            soft_reset_o   <= 1'b0;
            rx_dma_go_o    <= 1'b0;
            tx_dma_go_o    <= 1'b0;
            rx_burst_max_o <= MRC_BURST_32;
            tx_burst_max_o <= MRC_BURST_32;
            data_o         <= 32'h0000_0000;
            tester_port_o  <= '0;
            tester_hs_o    <= 2'h0;
            rx_chan_gnt_o  <= '0;
            tx_chan_gnt_o  <= '0;
        end else begin
            rx_ptr         <= next_rx_ptr;
            tx_ptr         <= next_tx_ptr;
            pci_oe_n_o     <= 1'b0; // Software reset does not float the bus
            soft_reset_o   <= soft_reset;
            rx_dma_go_o    <= rx_dma_req_i && master_configuration[MRC_RX_EN_BIT];
            tx_dma_go_o    <= tx_dma_req_i && master_configuration[MRC_TX_EN_BIT];
            rx_burst_max_o <= mrc_burst_len(master_configuration[MRC_RX_BURST_LSB +: 2]);
            tx_burst_max_o <= mrc_burst_len(master_configuration[MRC_TX_BURST_LSB +: 2]);
            data_o         <= swapped;
            tester_port_o  <= port_sel;
            tester_hs_o    <= hs_sel;
            rx_chan_gnt_o  <= rx_gnt;
            tx_chan_gnt_o  <= tx_gnt;
        end
    end

    assign reg_rdata_o = rdata;
endmodule : mrc_master_regs

/* tb/mrc_master_regs_properties.sv */
module mrc_chk #(
    parameter logic [7:0] REVISION  = 8'h01,
    parameter int         NUM_CHAN  = 64,
    parameter int         NUM_PORTS = 16
) (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire logic                 reg_sel_i,
    input wire logic                 reg_wr_i,
    input wire logic [11:0]          reg_addr_i,
    input wire logic [15:0]          reg_wdata_i,
    input wire logic [15:0]          reg_rdata_o,
    input wire logic                 pci_oe_n_o,
    input wire logic                 soft_reset_o,
    input wire logic                 rx_dma_req_i,
    input wire logic                 rx_dma_go_o,
    input wire logic [8:0]           rx_burst_max_o,
    input wire logic [8:0]           tx_burst_max_o,
    input wire logic                 data_is_packet_i,
    input wire logic [31:0]          data_i,
    input wire logic [31:0]          data_o,
    input wire logic [NUM_PORTS-1:0] tester_port_o,
    input wire logic [1:0]           tester_hs_o,
    input wire logic [NUM_CHAN-1:0]  rx_chan_req_i,
    input wire logic [NUM_CHAN-1:0]  rx_chan_gnt_o
);
    import mrc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Only the reset pin may float the PCI drivers
    chk_pci_drive_on: assert property (
        !$past(rst_i) |-> !pci_oe_n_o) else $error("pci drivers off outside reset pin");
    chk_pci_float_rst: assert property (
        disable iff (1'b0) rst_i |-> pci_oe_n_o && rx_burst_max_o == MRC_BURST_32 && reg_rdata_o == '0)
        else $error("reset pin state wrong");
    // A settled software reset shows defaults on the receive DMA gate, both burst limits and the tester port
    chk_soft_clear: assert property (
        soft_reset_o && $past(soft_reset_o) |-> !rx_dma_go_o && rx_burst_max_o == MRC_BURST_32
        && tx_burst_max_o == MRC_BURST_32 && tester_port_o == NUM_PORTS'(1))
        else $error("software reset left configuration active");
    chk_rev_read: assert property (
        reg_sel_i && !reg_wr_i && reg_addr_i == MRC_OFF_RESET_REV |=> reg_rdata_o[15:1] == {REVISION, 7'h00})
        else $error("revision read wrong");
    // Write effective next edge, limits one stage later
    chk_burst_map: assert property (
        reg_sel_i && reg_wr_i && reg_addr_i == MRC_OFF_MASTER_CFG ##1 !soft_reset_o
        |=> rx_burst_max_o == (MRC_BURST_32 << $past(reg_wdata_i[2:1], 2))
        && tx_burst_max_o == (MRC_BURST_32 << $past(reg_wdata_i[5:4], 2)))
        else $error("burst limit wrong");
    chk_rx_gate: assert property (
        rx_dma_go_o |-> $past(rx_dma_req_i)) else $error("receive dma moved without request");
    chk_tester_sel: assert property (
        $onehot0({tester_port_o, tester_hs_o})) else $error("tester select not one-hot");
    chk_gnt_req: assert property (
        $onehot0(rx_chan_gnt_o) && (rx_chan_gnt_o & ~$past(rx_chan_req_i)) == '0)
        else $error("grant without request");
    chk_plain_order: assert property (
        !$past(rst_i) && !$past(data_is_packet_i) |-> data_o == $past(data_i))
        else $error("non-packet data reordered");
endmodule : mrc_chk

bind mrc_master_regs mrc_chk #(.REVISION(REVISION), .NUM_CHAN(NUM_CHAN), .NUM_PORTS(NUM_PORTS)) i_chk (.*);

/* tb/mrc_host_model.sv */
module mrc_host_model (
    input  wire logic                           clk_i,
    output logic                                reg_sel_o,
    output logic                                reg_wr_o,
    output logic      [mrc_pkg::MRC_ADDR_W-1:0] reg_addr_o,
    output logic      [mrc_pkg::MRC_DATA_W-1:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import mrc_pkg::*;
    // Idle bus shows no stale value
    initial begin
        reg_sel_o = 1'b0;
        reg_wr_o = 1'b0;
        reg_addr_o = 12'hFFF;
        reg_wdata_o = 16'hFFFF;
    end
    // One-cycle access; lines inverted after release so nothing stale is read
    task automatic access(input logic wr, input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        reg_sel_o = 1'b1;
        reg_wr_o = wr;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge clk_i);
        #1;
        reg_sel_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask : access
endmodule : mrc_host_model

/* tb/master_reset_and_config_regs_tb.sv */
module master_reset_and_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mrc_pkg::*;
    localparam logic [7:0] REV = 8'h5A; // Arbitrary value
    logic        clk_i, rst_i, reg_sel_i, reg_wr_i, pci_oe_n_o, soft_reset_o, rd_seen;
    logic        rx_dma_req_i, rx_dma_go_o, tx_dma_req_i, tx_dma_go_o, data_is_packet_i;
    logic [11:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, tester_port_o, v;
    logic [8:0]  rx_burst_max_o, tx_burst_max_o;
    logic [31:0] data_i, data_o;
    logic [1:0]  tester_hs_o;
    logic [63:0] rx_chan_req_i, rx_chan_gnt_o, tx_chan_req_i, tx_chan_gnt_o, r;
    logic [15:0] exp_q[$];
    int          error_cnt, cmp_count, seed, g;

    mrc_master_regs #(.REVISION(REV)) i_dut (.*);
    mrc_host_model i_host (.clk_i(clk_i), .reg_sel_o(reg_sel_i), .reg_wr_o(reg_wr_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Watchdog bounds the whole run
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        end_sim();
    end
    // Read data stands one cycle after the strobe; oldest note pairs with it
    initial rd_seen = 1'b0;
    always @(posedge clk_i) begin
        if (rd_seen && exp_q.size() == 0) error_cnt++;
        else if (rd_seen) check(reg_rdata_o, exp_q.pop_front());
        rd_seen = reg_sel_i && !reg_wr_i && !rst_i;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        i_host.access(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        i_host.access(1'b0, a, 16'h0000);
    endtask : rd
    task automatic end_sim;
        if (exp_q.size() != 0) error_cnt++;
        $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim

    initial begin
        seed = 32'hc85acd5a;
        {rst_i, rx_dma_req_i, tx_dma_req_i, data_is_packet_i} = 4'h8;
        {data_i, rx_chan_req_i, tx_chan_req_i} = '0;
        step(20);
        rst_i = 1'b0;
        rd(MRC_OFF_RESET_REV, {REV, 8'h00});
        rd(MRC_OFF_MASTER_CFG, 16'h0000);
        rd(12'h020, 16'h0000);
        // Every burst code, enables kept off until setup is done
        for (int c = 0; c < 4; c++) begin
            v = (16'($random(seed)) & 16'hFFC0) | 16'(c << 1) | 16'(c << 4);
            wr(MRC_OFF_MASTER_CFG, v);
            rd(MRC_OFF_MASTER_CFG, v);
            check(rx_burst_max_o, MRC_BURST_32 << c);
            check(tx_burst_max_o, MRC_BURST_32 << c);
        end
        // Tester codes 0 to 19, unused ones 18 and 19 included
        for (int c = 0; c < 20; c++) begin
            wr(MRC_OFF_MASTER_CFG, 16'(c << 7));
            step(1);
            check(tester_port_o, c < 16 ? 16'(1 << c) : 16'h0000);
            check(tester_hs_o, (c == 16 || c == 17) ? 2'(1 << (c - 16)) : 2'h0);
        end
        // DMA gates with requests pending
        {rx_dma_req_i, tx_dma_req_i} = 2'h3;
        step(2);
        check({rx_dma_go_o, tx_dma_go_o}, 2'h0);
        wr(MRC_OFF_MASTER_CFG, 16'h0009);
        step(1);
        check({rx_dma_go_o, tx_dma_go_o}, 2'h3);
        // Packet data swapped only when big-endian
        wr(MRC_OFF_MASTER_CFG, 16'h0040);
        data_i = $random(seed);
        data_is_packet_i = 1'b1;
        step(2);
        check(data_o, {data_i[7:0], data_i[15:8], data_i[23:16], data_i[31:24]});
        data_is_packet_i = 1'b0;
        step(1);
        check(data_o, data_i);
        wr(MRC_OFF_MASTER_CFG, 16'h0000);
        data_is_packet_i = 1'b1;
        step(2);
        check(data_o, data_i);
        // Priority groups of 2, 16 and 64 with one request at the group edge
        for (int k = 1; k < 4; k++) begin
            g = (k == 1) ? 2 : (k == 2) ? 16 : 64;
            wr(MRC_OFF_MASTER_CFG, 16'(k * 16'h5000));
            r = {$random(seed), $random(seed)} | (64'h1 << (g - 1));
            {rx_chan_req_i, tx_chan_req_i} = {r, r};
            step(1);
            check(rx_chan_gnt_o, r & -r);
            check(tx_chan_gnt_o, r & -r);
            {rx_chan_req_i, tx_chan_req_i} = '0;
        end
        // Software reset: defaults held, writes refused, drivers kept on
        wr(MRC_OFF_MASTER_CFG, 16'h0049);
        wr(MRC_OFF_RESET_REV, 16'hFFFF);
        rd(MRC_OFF_RESET_REV, {REV, 8'h01});
        wr(MRC_OFF_MASTER_CFG, 16'h1234);
        rd(MRC_OFF_MASTER_CFG, 16'h0000);
        // Registered copy of the reset bit must be visible to the rest of the device
        check({pci_oe_n_o, rx_dma_go_o, soft_reset_o}, 3'h1);
        wr(MRC_OFF_RESET_REV, 16'h0000);
        wr(MRC_OFF_MASTER_CFG, 16'h1234);
        rd(MRC_OFF_MASTER_CFG, 16'h1234);
        // Reset pin mid-run clears the software reset bit too
        wr(MRC_OFF_RESET_REV, 16'h0001);
        rst_i = 1'b1;
        step(1);
        check({pci_oe_n_o, rx_burst_max_o, soft_reset_o}, {1'b1, MRC_BURST_32, 1'b0});
        rst_i = 1'b0;
        rd(MRC_OFF_RESET_REV, {REV, 8'h00});
        rd(MRC_OFF_MASTER_CFG, 16'h0000);
        step(2);
        end_sim();
    end
endmodule : master_reset_and_config_regs_tb
